//--- common/bdeu_pkg.sv
// constants and carrier types of the breakpoint and debug-event unit
// assumes one core clock; all event inputs come from logic on that clock
package bdeu_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_SLOT_BASE = 8'h00;
  localparam logic [7:0] OFF_SLOT_END = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_CTRL = 8'h1C;
  localparam logic [7:0] OFF_CFG = 8'h20;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int NUM_SLOTS = 4;
  localparam int CTRL_GD_BIT = 13;
  localparam int CTRL_TYPE_LSB = 16;
  localparam int CTRL_LEN_LSB = 18;
  localparam int CTRL_SLOT_STRIDE = 4;
  localparam int STAT_BD_BIT = 13;
  localparam int STAT_BS_BIT = 14;
  localparam int STAT_BT_BIT = 15;
  localparam int CFG_EXT_BIT = 0;
  localparam logic [31:0] CTRL_LOCAL_MASK = 32'h0000_0055;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [31:0] SLOT_RST = 32'h0000_0000;
  localparam logic CFG_EXT_RST = 1'b0;
  // ----------------------------------------
  // access type and length codes
  // ----------------------------------------
  localparam logic [1:0] TYPE_EXEC = 2'h0;
  localparam logic [1:0] TYPE_WR = 2'h1;
  localparam logic [1:0] TYPE_IO = 2'h2;
  localparam logic [1:0] TYPE_RW = 2'h3;
  localparam logic [1:0] LEN_1 = 2'h0;
  localparam logic [1:0] LEN_2 = 2'h1;
  localparam logic [1:0] LEN_4 = 2'h3;

  typedef struct packed {
    logic valid;
    logic we;
    logic [31:0] addr;
    logic [1:0] size;
  } bdeu_acc_t;

  typedef struct packed {
    logic real_mode;
    logic system_management_mode;
    logic [1:0] current_privilege_level;
  } bdeu_priv_t;
endpackage

//--- hw/bdeu_core.sv
// breakpoint and debug-event unit: four address slots, status, control
// assumes the core presents execute, data and i/o events on clk, and that
// debug-register moves arrive as classic wishbone cycles with privilege state
//
// The address map and the Wishbone register port were decided locally.
module bdeu_core
  import bdeu_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire bdeu_priv_t priv,
  input wire logic exec_valid,
  input wire logic [31:0] exec_addr,
  input wire bdeu_acc_t mem_acc,
  input wire bdeu_acc_t io_acc,
  input wire logic insn_done,
  input wire logic single_step_flag,
  input wire logic resume_flag,
  input wire logic task_switch,
  input wire logic task_trap_bit,
  input wire logic brk_insn,
  output logic debug_exception,
  output logic breakpoint_exception,
  output logic general_protection_fault
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] len_mask(input logic [1:0] len);
    case (len)
      LEN_1: len_mask = 4'h1;
      LEN_2: len_mask = 4'h3;
      default: len_mask = 4'hF;
    endcase
  endfunction

  // access that crosses a dword only compares its first dword: the core
  // splits such accesses anyway
  function automatic logic range_hit(input logic [31:0] base, input logic [1:0] len,
                                     input logic [31:0] addr, input logic [1:0] size);
    logic [3:0] sm;
    logic [3:0] am;
    logic [3:0] lm;
    lm = len_mask(len);
    // length masks the low base bits, so a misaligned base still covers its aligned span
    sm = lm << (base[1:0] & ~lm[2:1]);
    am = len_mask(size) << addr[1:0];
    range_hit = (base[31:2] == addr[31:2]) && ((sm & am) != 4'h0);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] slot_r [NUM_SLOTS];
  logic [31:0] ctrl_r;
  logic [15:0] status_r;
  logic ext_r;
  logic ack_r;
  logic blocked_r;
  logic [31:0] dat_r;
  logic dbg_r;
  logic bp_r;
  logic gp_r;

  // ----------------------------------------
  // condition detection
  // ----------------------------------------
  logic [3:0] cond_hit;
  logic [3:0] exec_kind;
  logic [3:0] slot_en;
  logic bp_fire;
  logic step_fire;
  logic task_fire;
  logic attempt;
  logic priv_ok;
  logic gd_fire;
  logic gp_fire;
  logic dbg_fire;
  logic wr_take;
  logic [31:0] rd_val;

  always_comb begin
    logic [1:0] typ;
    logic [1:0] len;
    typ = TYPE_EXEC;
    len = LEN_1;
    cond_hit = 4'h0;
    exec_kind = 4'h0;
    slot_en = 4'h0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      typ = ctrl_r[CTRL_TYPE_LSB + CTRL_SLOT_STRIDE*i +: 2];
      len = ctrl_r[CTRL_LEN_LSB + CTRL_SLOT_STRIDE*i +: 2];
      slot_en[i] = ctrl_r[2*i] | ctrl_r[2*i+1];
      case (typ)
        TYPE_EXEC: begin
          cond_hit[i] = exec_valid && (exec_addr == slot_r[i]);
          exec_kind[i] = 1'b1;
        end
        TYPE_WR: cond_hit[i] = mem_acc.valid && mem_acc.we && range_hit(slot_r[i], len, mem_acc.addr, mem_acc.size);
        TYPE_IO: cond_hit[i] = ext_r && io_acc.valid
                               && range_hit(slot_r[i], len, {16'h0000, io_acc.addr[15:0]}, io_acc.size);
        default: cond_hit[i] = mem_acc.valid && range_hit(slot_r[i], len, mem_acc.addr, mem_acc.size);
      endcase
    end
  end

  // resume only masks instruction breaks; data and i/o breaks still fire
  assign bp_fire = |(cond_hit & slot_en & ~(exec_kind & {4{resume_flag}}));
  assign step_fire = insn_done & single_step_flag;
  assign task_fire = task_switch & task_trap_bit;
  assign attempt = wb_cyc_i & wb_stb_i & ~ack_r;
  assign priv_ok = priv.real_mode | priv.system_management_mode | (priv.current_privilege_level == 2'h0);
  assign gp_fire = attempt & ~priv_ok;
  assign gd_fire = attempt & priv_ok & ctrl_r[CTRL_GD_BIT];
  assign dbg_fire = bp_fire | step_fire | task_fire | gd_fire;
  assign wr_take = wb_cyc_i & wb_stb_i & ack_r & wb_we_i & ~blocked_r;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (wb_adr_i < OFF_SLOT_END) begin
      rd_val = slot_r[wb_adr_i[3:2]];
    end else if (wb_adr_i == OFF_STATUS) begin
      rd_val = {16'h0000, status_r};
    end else if (wb_adr_i == OFF_CTRL) begin
      rd_val = ctrl_r;
    end else if (wb_adr_i == OFF_CFG) begin
      rd_val[CFG_EXT_BIT] = ext_r;
    end
  end

  // ----------------------------------------
  // bus slave: ack one cycle after the request
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
    end
  end

  // a refused move still completes on the bus, reads zero and writes nothing
  always_ff @(posedge clk) begin
    if (srst) begin
      blocked_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else if (attempt) begin
      blocked_r <= ~priv_ok | ctrl_r[CTRL_GD_BIT];
      dat_r <= (~priv_ok | ctrl_r[CTRL_GD_BIT]) ? 32'h0000_0000 : rd_val;
    end
  end

  // ----------------------------------------
  // address slots
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_r[i] <= SLOT_RST;
      end
    end else if (wr_take && wb_adr_i < OFF_SLOT_END) begin
      slot_r[wb_adr_i[3:2]] <= merge(slot_r[wb_adr_i[3:2]], wb_dat_i, wb_sel_i);
    end
  end

  // ----------------------------------------
  // control: hardware clears win over a same-cycle write
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= CTRL_RST;
    end else begin
      logic [31:0] c;
      c = ctrl_r;
      if (wr_take && wb_adr_i == OFF_CTRL) begin
        c = merge(c, wb_dat_i, wb_sel_i);
      end
      if (task_switch) begin
        c = c & ~CTRL_LOCAL_MASK;
      end
      if (dbg_fire) begin
        c[CTRL_GD_BIT] = 1'b0; // handler must be able to reach the registers
      end
      ctrl_r <= c;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_r <= CFG_EXT_RST;
    end else if (wr_take && wb_adr_i == OFF_CFG && wb_sel_i[0]) begin
      ext_r <= wb_dat_i[CFG_EXT_BIT];
    end
  end

  // ----------------------------------------
  // status: software clears, a same-cycle event still sets
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      status_r <= STAT_RST;
    end else begin
      logic [15:0] s;
      logic [31:0] m;
      s = status_r;
      m = merge({16'h0000, s}, wb_dat_i, wb_sel_i);
      if (wr_take && wb_adr_i == OFF_STATUS) begin
        s = m[15:0];
      end
      if (dbg_fire || brk_insn) begin
        s[3:0] = s[3:0] | cond_hit;
        s[STAT_BD_BIT] = s[STAT_BD_BIT] | gd_fire;
        s[STAT_BS_BIT] = s[STAT_BS_BIT] | step_fire;
        s[STAT_BT_BIT] = s[STAT_BT_BIT] | task_fire;
      end
      status_r <= s;
    end
  end

  // ----------------------------------------
  // exception pulses
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      dbg_r <= 1'b0;
      bp_r <= 1'b0;
      gp_r <= 1'b0;
    end else begin
      dbg_r <= dbg_fire;
      bp_r <= brk_insn;
      gp_r <= gp_fire;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign debug_exception = dbg_r;
  assign breakpoint_exception = bp_r;
  assign general_protection_fault = gp_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_gd_attempt;
    attempt && priv_ok && ctrl_r[CTRL_GD_BIT];
  endsequence
  sequence s_trap_then_clear;
    debug_exception && status_r[STAT_BD_BIT] && !ctrl_r[CTRL_GD_BIT];
  endsequence
  sequence s_user_write;
    attempt && !priv_ok && wb_we_i && wb_adr_i == OFF_SLOT_BASE;
  endsequence

  a_gp_user_move: assert property (attempt && !priv_ok |=> general_protection_fault && !debug_exception)
    else $error("no protection fault on unprivileged move");
  a_user_write_dropped: assert property (s_user_write |=> ##1 $stable(slot_r[0]))
    else $error("unprivileged write reached a slot");
  a_gd_trap_clear: assert property (s_gd_attempt |=> s_trap_then_clear ##1 wb_dat_o == 32'h0000_0000)
    else $error("general detect did not trap and clear");
  a_step_trap: assert property (insn_done && single_step_flag |=> debug_exception && status_r[STAT_BS_BIT])
    else $error("single step did not trap");
  a_task_trap: assert property (task_switch && task_trap_bit |=> debug_exception && status_r[STAT_BT_BIT])
    else $error("trapped task switch missed");
  a_local_cleared: assert property (task_switch |=> (ctrl_r & CTRL_LOCAL_MASK) == 32'h0000_0000
                                    && ctrl_r[7:0] == ($past(ctrl_r[7:0]) & 8'hAA))
    else $error("local enables not cleared on task switch");
  a_hits_recorded: assert property (bp_fire |=> debug_exception
                                    && ((status_r[3:0] & $past(cond_hit)) == $past(cond_hit)))
    else $error("matching slots not all recorded");
  a_resume_masks: assert property (resume_flag && !step_fire && !task_fire && !gd_fire
                                   && (cond_hit & slot_en & ~exec_kind) == 4'h0 |=> !debug_exception)
    else $error("instruction break fired under resume");
  a_brk_insn: assert property (brk_insn |=> breakpoint_exception)
    else $error("breakpoint instruction missed");
  a_ack_one: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");
  a_reset_ctrl: assert property (disable iff (1'b0) srst |=> ctrl_r == CTRL_RST)
    else $error("enables survive reset");
endmodule

//--- verif/bdeu_cpu_model.sv
// core model: drives execute, data, i/o and flow events, one pulse per call
// assumes the bench calls ev between its own bus cycles, on the core clock
module bdeu_cpu_model
  import bdeu_pkg::*;
(
  input wire logic clk,
  output logic exec_valid,
  output logic [31:0] exec_addr,
  output bdeu_acc_t mem_acc,
  output bdeu_acc_t io_acc,
  output logic insn_done,
  output logic single_step_flag,
  output logic resume_flag,
  output logic task_switch,
  output logic task_trap_bit,
  output logic brk_insn
);
  timeunit 1ns;
  timeprecision 1ps;
  // released address lines show the inverse, so a stale match cannot pass
  task automatic idle(input logic [31:0] a);
    {exec_valid, insn_done, single_step_flag, resume_flag, task_switch, task_trap_bit, brk_insn} <= 7'h00;
    exec_addr <= ~a;
    mem_acc <= '{1'b0, 1'b0, ~a, 2'h2};
    io_acc <= '{1'b0, 1'b0, ~a, 2'h2};
  endtask
  initial idle(32'h0);
  // k: 0 exec, 1 write, 2 read, 3 i/o, 4 step, 5 switch, 6 brk
  task automatic ev(input int k, input logic [31:0] a, input logic rf);
    @(posedge clk);
    resume_flag <= rf;
    exec_valid <= k == 0;
    exec_addr <= a;
    mem_acc <= '{k == 1 || k == 2, k == 1, a, LEN_4};
    io_acc <= '{k == 3, 1'b0, a, LEN_1};
    insn_done <= k == 4;
    single_step_flag <= k == 4;
    task_switch <= k == 5;
    task_trap_bit <= k == 5;
    brk_insn <= k == 6;
    @(posedge clk);
    idle(a);
  endtask
endmodule

//--- verif/test_bdeu_core.sv
// bench for the breakpoint and debug-event unit
// assumes the core model drives events; the bench drives wishbone and privilege
module test_bdeu_core
  import bdeu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [3:0] lanes = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, exec_valid, insn_done, single_step_flag, resume_flag, task_switch, task_trap_bit, brk_insn;
  logic debug_exception, breakpoint_exception, general_protection_fault;
  logic [31:0] exec_addr;
  bdeu_acc_t mem_acc, io_acc;
  bdeu_priv_t priv = '0;
  int errors = 0;
  int n_tests = 0;
  always #10 clk = ~clk;
  bdeu_core u_bdeu_core (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .priv, .exec_valid, .exec_addr, .mem_acc, .io_acc, .insn_done, .single_step_flag,
    .resume_flag, .task_switch, .task_trap_bit, .brk_insn, .debug_exception, .breakpoint_exception,
    .general_protection_fault);
  bdeu_cpu_model u_bdeu_cpu_model (.clk, .exec_valid, .exec_addr, .mem_acc, .io_acc, .insn_done,
    .single_step_flag, .resume_flag, .task_switch, .task_trap_bit, .brk_insn);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // request stands until ack is seen high at a rising edge; answer is taken at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q, output logic f, output logic x);
    int i;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= lanes;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 20) begin
      errors++;
      finish_test();
    end
    q = wb_dat_o;
    f = general_protection_fault;
    x = debug_exception;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic f, x;
    wb(1'b1, a, d, q, f, x);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic f, x;
    wb(1'b0, a, 32'h0, q, f, x);
    chk(n, e, q);
  endtask
  task automatic stat(input logic [31:0] e);
    rd("status", OFF_STATUS, e);
    wr(OFF_STATUS, 32'h0);
  endtask
  task automatic evc(input int k, input logic [31:0] a, input logic rf, input logic edb, input logic ebp);
    u_bdeu_cpu_model.ev(k, a, rf);
    @(negedge clk);
    chk("debug_exception", edb, debug_exception);
    chk("breakpoint_exception", ebp, breakpoint_exception);
  endtask
  task automatic setp(input bdeu_priv_t p);
    @(posedge clk);
    priv <= p;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_priv();
    logic [31:0] q;
    logic f, x;
    rd("control", OFF_CTRL, CTRL_RST);
    setp('{1'b0, 1'b0, 2'h3});
    wb(1'b1, OFF_CTRL, 32'h0000_00FF, q, f, x);
    chk("fault on write", 1'b1, f);
    wb(1'b1, OFF_SLOT_BASE, 32'h0000_0055, q, f, x);
    chk("fault on slot write", 1'b1, f);
    wb(1'b0, OFF_CTRL, 32'h0, q, f, x);
    chk("fault on read", 1'b1, f);
    setp('{1'b0, 1'b1, 2'h3});
    rd("control in smm", OFF_CTRL, 32'h0);
    rd("slot0 in smm", OFF_SLOT_BASE, 32'h0);
    setp('{1'b1, 1'b0, 2'h3});
    wr(OFF_SLOT_BASE, 32'h0000_0155);
    lanes = 4'h1;
    wr(OFF_SLOT_BASE, 32'hFFFF_FF00);
    lanes = 4'hF;
    rd("slot0 in real mode", OFF_SLOT_BASE, 32'h0000_0100);
    setp('{1'b0, 1'b0, 2'h0});
    $display("privilege test done");
  endtask
  task automatic t_data();
    wr(8'h04, 32'h0000_0103);
    wr(8'h08, 32'h0000_2000);
    wr(8'h0C, 32'h0000_0060);
    wr(OFF_CFG, 32'h1);
    wr(OFF_CTRL, 32'h203D_0092);
    rd("control", OFF_CTRL, 32'h203D_0092);
    evc(1, 32'h100, 1'b0, 1'b1, 1'b0);
    stat(32'h3);
    evc(2, 32'h103, 1'b0, 1'b0, 1'b0);
    evc(1, 32'h104, 1'b0, 1'b0, 1'b0);
    evc(3, 32'h60, 1'b0, 1'b1, 1'b0);
    stat(32'h8);
    $display("data test done");
  endtask
  task automatic t_flow();
    evc(0, 32'h2000, 1'b1, 1'b0, 1'b0);
    evc(0, 32'h2000, 1'b0, 1'b1, 1'b0);
    stat(32'h4);
    evc(4, 32'h0, 1'b0, 1'b1, 1'b0);
    stat(32'h4000);
    evc(6, 32'h0, 1'b0, 1'b0, 1'b1);
    evc(5, 32'h0, 1'b0, 1'b1, 1'b0);
    stat(32'h8000);
    rd("control after switch", OFF_CTRL, 32'h203D_0082);
    $display("flow test done");
  endtask
  task automatic t_detect();
    logic [31:0] q;
    logic f, x;
    wr(OFF_CTRL, 32'h203D_2082);
    wb(1'b0, OFF_CTRL, 32'h0, q, f, x);
    chk("detect exception", 1'b1, x);
    chk("detect read data", 32'h0, q);
    rd("control after detect", OFF_CTRL, 32'h203D_0082);
    stat(32'h2000);
    $display("detect test done");
  endtask
  task automatic t_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd("control after reset", OFF_CTRL, CTRL_RST);
    rd("slot0 after reset", OFF_SLOT_BASE, SLOT_RST);
    $display("reset test done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_priv();
    t_data();
    t_flow();
    t_detect();
    t_reset();
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule
